// ### common/odc_pkg.sv
/*
 * Constants, register map and carrier types for the output channel divider control block.
 * Assumes a single 50 MHz clock mclk that also serves as the divider input clock.
 */
// Summary of operation
// - Low time is low-count field plus one.
// - High time is high-count field plus one.
// - Bypass passes input clock straight to output.
// - Ignore bit makes divider disregard chip sync.
// - Force drives static start level, needs ignore.
// - Force has no effect while divider bypassed.
// - Start-high bit picks the initial output level.
// - Phase offset delays output after sync, resets zero.
// - Channel power-down puts three outputs safe low.
// - Direct bit routes oscillator or external clock.
// - Direct bit clear feeds outputs from divider.
// - Correction disable bit turns duty correction off.
package odc_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [9:0] ODC_ADDR_CH2_OUT = 10'h198;
  localparam logic [9:0] ODC_ADDR_CH3_CNT = 10'h199;
  localparam logic [9:0] ODC_ADDR_CH3_DIV = 10'h19A;
  localparam logic [9:0] ODC_ADDR_CH3_OUT = 10'h19B;
  localparam logic [9:0] ODC_ADDR_OSC_DIV = 10'h1E0;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int ODC_BIT_BYPASS  = 7;
  localparam int ODC_BIT_IGNSYNC = 6;
  localparam int ODC_BIT_FORCE   = 5;
  localparam int ODC_BIT_STARTHI = 4;
  localparam int ODC_BIT_PWRDN   = 2;
  localparam int ODC_BIT_DIRECT  = 1;
  localparam int ODC_BIT_CORRDIS = 0;
  // ****************************************
  // Reset values and codes
  // ****************************************
  localparam logic [7:0] ODC_RST_CNT     = 8'h00;
  localparam logic [7:0] ODC_RST_DIV     = 8'h00;
  localparam logic [2:0] ODC_RST_OUT     = 3'h0;
  localparam logic [2:0] ODC_RST_OSC     = 3'h0;
  localparam logic [1:0] ODC_SRC_OSC     = 2'h2;
  localparam logic [1:0] ODC_SRC_EXT     = 2'h0;
  localparam logic [2:0] ODC_OSC_BYPASS  = 3'h6;
  localparam logic [2:0] ODC_OSC_STATIC0 = 3'h5;
  localparam logic [2:0] ODC_OSC_STATIC1 = 3'h7;
  localparam logic [2:0] ODC_OSC_BASE    = 3'h2;

  typedef struct packed {
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
    logic       bypass;
    logic       ign_sync;
    logic       force_out;
    logic       start_high;
    logic [3:0] phase;
  } odc_div_cfg_t;

  typedef struct packed {
    logic [9:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } odc_reg_req_t;

  typedef enum logic [1:0] {
    ODC_ST_DELAY = 2'b01,
    ODC_ST_RUN   = 2'b10
  } odc_div_st_t;
endpackage

// ### src/odc_chan_div.sv
/*
 * One channel divider: high and low counts, start level, phase delay, sync, force and bypass.
 * Assumes tick marks each divider input cycle and cfg is synchronous to mclk.
 */
`timescale 1ns/1ns
module odc_chan_div
  import odc_pkg::*;
#(
  parameter int CNT_W = 4
) (
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic         tick,
  input  wire logic         sync,
  input  wire odc_div_cfg_t cfg,
  output logic              div_out
);
  if (CNT_W != 4) begin : g_chk
    $error("odc_chan_div: CNT_W must be 4");
  end

  odc_div_st_t st_r, st_nxt;
  logic       lvl_r, lvl_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [3:0] dly_r, dly_nxt;
  logic       sync_hit;

  // ****************************************
  // Divider sequencing
  // ****************************************
  assign sync_hit = sync && !cfg.ign_sync && !cfg.bypass;

  always_comb begin
    st_nxt  = st_r;
    lvl_nxt = lvl_r;
    cnt_nxt = cnt_r;
    dly_nxt = dly_r;
    if (sync_hit) begin
      lvl_nxt = cfg.start_high;
      cnt_nxt = cfg.start_high ? cfg.high_cnt : cfg.low_cnt;
      dly_nxt = cfg.phase;
      st_nxt  = (cfg.phase == 4'h0) ? ODC_ST_RUN : ODC_ST_DELAY;
    end else if (tick) begin
      case (st_r)
        ODC_ST_DELAY: begin
          dly_nxt = dly_r - 4'h1;
          if (dly_r <= 4'h1) begin
            st_nxt = ODC_ST_RUN;
          end
        end
        ODC_ST_RUN: begin
          if (cnt_r == 4'h0) begin
            lvl_nxt = !lvl_r;
            cnt_nxt = lvl_r ? cfg.low_cnt : cfg.high_cnt;
          end else begin
            cnt_nxt = cnt_r - 4'h1;
          end
        end
        default: st_nxt = ODC_ST_RUN;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r  <= ODC_ST_RUN;
      lvl_r <= 1'b0;
      cnt_r <= 4'h0;
      dly_r <= 4'h0;
    end else if (ce) begin
      st_r  <= st_nxt;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      dly_r <= dly_nxt;
    end
  end

  // ****************************************
  // Output selection
  // ****************************************
  always_comb begin
    if (cfg.bypass) begin
      div_out = tick;
    end else if (cfg.force_out && cfg.ign_sync) begin
      div_out = cfg.start_high;
    end else begin
      div_out = lvl_r;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  logic [4:0] run_r;
  logic [4:0] len_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_r <= 5'h00;
      len_r <= 5'h00;
    end else if (ce) begin
      if (sync_hit || lvl_nxt != lvl_r) begin
        run_r <= 5'h00;
        len_r <= {1'b0, cnt_nxt};
      end else if (tick && st_r == ODC_ST_RUN) begin
        run_r <= run_r + 5'h01;
      end
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  level_length_a: assert property (ce && tick && !sync_hit && st_r == ODC_ST_RUN && cnt_r == 4'h0
    |-> run_r == len_r) else $error("level held for wrong tick count");
  toggle_load_a: assert property (ce && tick && !sync_hit && st_r == ODC_ST_RUN && cnt_r == 4'h0
    |=> cnt_r == (lvl_r ? $past(cfg.high_cnt) : $past(cfg.low_cnt))) else $error("wrong count loaded");
  sync_start_a: assert property (ce && sync_hit |=> lvl_r == $past(cfg.start_high))
    else $error("sync did not set start level");
  sync_ignore_a: assert property (ce && sync && cfg.ign_sync && !tick |=> $stable(lvl_r) && $stable(st_r))
    else $error("ignored sync changed divider");
  phase_hold_a: assert property (ce && sync_hit && cfg.phase != 4'h0 |=> st_r == ODC_ST_DELAY)
    else $error("phase delay not entered");
  bypass_pass_a: assert property (cfg.bypass |-> div_out == tick) else $error("bypass not passing input");
  force_static_a: assert property (!cfg.bypass && cfg.force_out && cfg.ign_sync |-> div_out == cfg.start_high)
    else $error("forced level wrong");
  sync_cov: cover property (ce && sync_hit ##[1:40] ce && tick && lvl_r);
  toggle_cov: cover property (ce && tick && st_r == ODC_ST_RUN && cnt_r == 4'h0 && !lvl_r);
endmodule

// ### src/odc_out_div_ctl.sv
/*
 * Output channel divider control: configuration registers, oscillator ratio prescaler,
 * channel three divider, direct routing, power-down and duty-cycle correction flags.
 * Assumes a register port from the serial control logic, synchronous inputs and one clock.
 */
`timescale 1ns/1ns
module odc_out_div_ctl
  import odc_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire odc_reg_req_t reg_req,
  output logic [7:0]        reg_rdata,
  input  wire logic         sync_in,
  input  wire logic [1:0]   clk_src_sel,
  input  wire logic         osc_clk_in,
  input  wire logic         ext_clk_in,
  input  wire logic         ch2_div_in,
  output logic              group_c_output_a,
  output logic              group_c_output_b,
  output logic              group_c_output_c,
  output logic              group_d_output_a,
  output logic              group_d_output_b,
  output logic              group_d_output_c,
  output logic              ch2_duty_cycle_correction,
  output logic              ch3_duty_cycle_correction,
  output logic              div_in_tick
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] cnt3_r, cnt3_nxt;
  logic [7:0] div3_r, div3_nxt;
  logic [2:0] out3_r, out3_nxt;
  logic [2:0] out2_r, out2_nxt;
  logic [2:0] osc_r, osc_nxt;
  logic [7:0] rdat_r, rdat_nxt;

  always_comb begin
    cnt3_nxt = cnt3_r;
    div3_nxt = div3_r;
    out3_nxt = out3_r;
    out2_nxt = out2_r;
    osc_nxt  = osc_r;
    rdat_nxt = rdat_r;
    if (reg_req.wr) begin
      case (reg_req.addr)
        ODC_ADDR_CH2_OUT: out2_nxt = reg_req.wdata[2:0];
        ODC_ADDR_CH3_CNT: cnt3_nxt = reg_req.wdata;
        ODC_ADDR_CH3_DIV: div3_nxt = reg_req.wdata;
        ODC_ADDR_CH3_OUT: out3_nxt = reg_req.wdata[2:0];
        ODC_ADDR_OSC_DIV: osc_nxt  = reg_req.wdata[2:0];
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      case (reg_req.addr)
        ODC_ADDR_CH2_OUT: rdat_nxt = {5'h00, out2_r};
        ODC_ADDR_CH3_CNT: rdat_nxt = cnt3_r;
        ODC_ADDR_CH3_DIV: rdat_nxt = div3_r;
        ODC_ADDR_CH3_OUT: rdat_nxt = {5'h00, out3_r};
        ODC_ADDR_OSC_DIV: rdat_nxt = {5'h00, osc_r};
        default:          rdat_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt3_r <= ODC_RST_CNT;
      div3_r <= ODC_RST_DIV;
      out3_r <= ODC_RST_OUT;
      out2_r <= ODC_RST_OUT;
      osc_r  <= ODC_RST_OSC;
      rdat_r <= 8'h00;
    end else if (ce) begin
      cnt3_r <= cnt3_nxt;
      div3_r <= div3_nxt;
      out3_r <= out3_nxt;
      out2_r <= out2_nxt;
      osc_r  <= osc_nxt;
      rdat_r <= rdat_nxt;
    end
  end
  assign reg_rdata = rdat_r;

  // ****************************************
  // Oscillator ratio prescaler
  // ****************************************
  logic [2:0] pre_r, pre_nxt;
  logic [2:0] ratio_m1;
  logic       osc_static;

  always_comb begin
    osc_static = (osc_r == ODC_OSC_STATIC0) || (osc_r == ODC_OSC_STATIC1);
    if (osc_r == ODC_OSC_BYPASS) begin
      ratio_m1 = 3'h0;
    end else begin
      ratio_m1 = osc_r + 3'h1;
    end
    div_in_tick = !osc_static && (pre_r >= ratio_m1);
    pre_nxt     = (div_in_tick || osc_static) ? 3'h0 : pre_r + 3'h1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre_r <= 3'h0;
    end else if (ce) begin
      pre_r <= pre_nxt;
    end
  end

  // ****************************************
  // Channel three divider
  // ****************************************
  odc_div_cfg_t cfg3;
  logic         div3_out;

  always_comb begin
    cfg3.low_cnt    = cnt3_r[7:4];
    cfg3.high_cnt   = cnt3_r[3:0];
    cfg3.bypass     = div3_r[ODC_BIT_BYPASS];
    cfg3.ign_sync   = div3_r[ODC_BIT_IGNSYNC];
    cfg3.force_out  = div3_r[ODC_BIT_FORCE];
    cfg3.start_high = div3_r[ODC_BIT_STARTHI];
    cfg3.phase      = div3_r[3:0];
  end

  odc_chan_div #(
    .CNT_W (4)
  ) u_div3 (
    .mclk    (mclk),
    .rst     (rst),
    .ce      (ce),
    .tick    (div_in_tick),
    .sync    (sync_in),
    .cfg     (cfg3),
    .div_out (div3_out)
  );

  // ****************************************
  // Routing and power-down
  // ****************************************
  function automatic logic route(input logic [2:0] oc, input logic div_lvl, input logic [1:0] sel,
                                 input logic osc, input logic ext);
    logic v;
    v = div_lvl;
    if (oc[ODC_BIT_DIRECT] && sel == ODC_SRC_OSC) begin
      v = osc;
    end else if (oc[ODC_BIT_DIRECT] && sel == ODC_SRC_EXT) begin
      v = ext;
    end
    route = v && !oc[ODC_BIT_PWRDN];
  endfunction

  logic c_r, c_nxt;
  logic d_r, d_nxt;

  always_comb begin
    c_nxt = route(out2_r, ch2_div_in, clk_src_sel, osc_clk_in, ext_clk_in);
    d_nxt = route(out3_r, div3_out, clk_src_sel, osc_clk_in, ext_clk_in);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      c_r <= 1'b0;
      d_r <= 1'b0;
    end else if (ce) begin
      c_r <= c_nxt;
      d_r <= d_nxt;
    end
  end

  assign group_c_output_a = c_r;
  assign group_c_output_b = c_r;
  assign group_c_output_c = c_r;
  assign group_d_output_a = d_r;
  assign group_d_output_b = d_r;
  assign group_d_output_c = d_r;
  assign ch2_duty_cycle_correction = !out2_r[ODC_BIT_CORRDIS];
  assign ch3_duty_cycle_correction = !out3_r[ODC_BIT_CORRDIS] && !div3_r[ODC_BIT_BYPASS];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  power_down_a: assert property (ce && out3_r[ODC_BIT_PWRDN] |=> !group_d_output_a && !group_d_output_c)
    else $error("powered-down channel drives high");
  power_down_c_a: assert property (ce && out2_r[ODC_BIT_PWRDN] |=> !group_c_output_a && !group_c_output_b)
    else $error("powered-down channel two drives high");
  direct_osc_a: assert property (ce && out3_r[ODC_BIT_DIRECT] && clk_src_sel == ODC_SRC_OSC
    && !out3_r[ODC_BIT_PWRDN] |=> group_d_output_b == $past(osc_clk_in))
    else $error("oscillator not routed");
  direct_ext_a: assert property (ce && out3_r[ODC_BIT_DIRECT] && clk_src_sel == ODC_SRC_EXT
    && !out3_r[ODC_BIT_PWRDN] |=> group_d_output_c == $past(ext_clk_in))
    else $error("external clock not routed");
  direct_none_a: assert property (ce && out3_r[ODC_BIT_DIRECT] && clk_src_sel[0]
    && !out3_r[ODC_BIT_PWRDN] |=> group_d_output_b == $past(div3_out))
    else $error("no-effect select changed routing");
  divider_feed_a: assert property (ce && !out3_r[ODC_BIT_DIRECT] && !out3_r[ODC_BIT_PWRDN]
    |=> group_d_output_a == $past(div3_out)) else $error("divider not feeding outputs");
  ch2_feed_a: assert property (ce && !out2_r[ODC_BIT_DIRECT] && !out2_r[ODC_BIT_PWRDN]
    |=> group_c_output_c == $past(ch2_div_in)) else $error("channel two input not feeding outputs");
  count_write_a: assert property (ce && reg_req.wr && reg_req.addr == ODC_ADDR_CH3_CNT
    |=> cnt3_r == $past(reg_req.wdata)) else $error("count write lost");
  ratio_two_a: assert property (ce && osc_r == ODC_RST_OSC && div_in_tick && !reg_req.wr
    ##1 ce |-> !div_in_tick) else $error("divide-by-two ticks too close");
  static_ratio_a: assert property (osc_static |-> !div_in_tick) else $error("static ratio ticking");
  corr_flag_a: assert property (ce && reg_req.wr && reg_req.addr == ODC_ADDR_CH3_OUT && reg_req.wdata[0]
    |=> !ch3_duty_cycle_correction) else $error("correction not disabled");

  // ****************************************
  // Coverage
  // ****************************************
  bypass_cov: cover property (ce && div3_r[ODC_BIT_BYPASS] && div_in_tick);
  direct_cov: cover property (ce && out3_r[ODC_BIT_DIRECT] && clk_src_sel == ODC_SRC_EXT);
  pwrdn_cov: cover property (ce && out2_r[ODC_BIT_PWRDN]);
endmodule

// ### testbench/odc_out_div_ctl_test.sv
/* Self-checking bench for the output channel divider control block.
   Assumes odc_pkg and the design sources are compiled before this file. */
`timescale 1ns/1ns
module odc_out_div_ctl_test
  import odc_pkg::*;
;
  logic         mclk = 1'b0;
  logic         rst;
  logic         ce;
  odc_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         sync_in;
  logic [1:0]   clk_src_sel;
  logic         osc_clk_in, ext_clk_in, ch2_div_in;
  logic         gca, gcb, gcc, gda, gdb, gdc;
  logic         cor2, cor3, div_in_tick;
  int           err_total = 0;
  int           total_checks = 0;
  logic [7:0]   d, w;
  int           hi, lo, c, t0, t1, p;
  logic [9:0]   adr [5] = '{ODC_ADDR_CH2_OUT, ODC_ADDR_CH3_CNT, ODC_ADDR_CH3_DIV, ODC_ADDR_CH3_OUT, ODC_ADDR_OSC_DIV};
  logic [7:0]   msk [5] = '{8'h07, 8'hFF, 8'hFF, 8'h07, 8'h07};

  odc_out_div_ctl i_odc_out_div_ctl (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata), .sync_in(sync_in),
    .clk_src_sel(clk_src_sel), .osc_clk_in(osc_clk_in), .ext_clk_in(ext_clk_in), .ch2_div_in(ch2_div_in),
    .group_c_output_a(gca), .group_c_output_b(gcb), .group_c_output_c(gcc), .group_d_output_a(gda),
    .group_d_output_b(gdb), .group_d_output_c(gdc), .ch2_duty_cycle_correction(cor2),
    .ch3_duty_cycle_correction(cor3), .div_in_tick(div_in_tick)
  );

  always #10 mclk = ~mclk;

  always @(posedge mclk) begin
    osc_clk_in <= 1'($urandom);
    ext_clk_in <= 1'($urandom);
    ch2_div_in <= 1'($urandom);
  end

  // ****************************************
  // Checking and bus tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end
    else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  function automatic int exp_len(input logic [3:0] f, input int code);
    return (int'(f) + 1) * ((code == 6) ? 1 : code + 2);
  endfunction

  task automatic reg_wr(input logic [9:0] a, input logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{a, 1'b1, 1'b0, v};
    @(posedge mclk);
    reg_req <= '{a, 1'b0, 1'b0, v};
  endtask

  task automatic reg_rd(input logic [9:0] a, output logic [7:0] v);
    @(posedge mclk);
    reg_req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge mclk);
    reg_req <= '{a, 1'b0, 1'b0, 8'h00};
    @(posedge mclk);
    v = reg_rdata;
  endtask

  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (gda !== v) begin
      @(posedge mclk);
      n++;
      if (n > 600) begin
        err_total++;
        $display("BAD t=%0t output stuck", $time);
        finish_test();
      end
    end
  endtask

  // Compares a whole output group each cycle against a level or a one-cycle-old input.
  task automatic span(input int n, input logic grp, input int m, input logic v);
    logic e;
    int   bad;
    bad = 0;
    repeat (3) @(posedge mclk);
    repeat (n) begin
      e = (m == 1) ? div_in_tick : (m == 2) ? osc_clk_in : (m == 3) ? ext_clk_in : (m == 4) ? ch2_div_in : v;
      @(posedge mclk);
      bad += (grp ? {gca, gcb, gcc} : {gda, gdb, gdc}) !== {3{e}};
    end
    chk(16'(bad), 16'h0000, "output group");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(95899));
    rst = 1'b1;
    ce = 1'b1;
    reg_req = '0;
    sync_in = 1'b0;
    clk_src_sel = 2'h1;
    osc_clk_in = 1'b0;
    ext_clk_in = 1'b0;
    ch2_div_in = 1'b0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      reg_rd(adr[i], d);
      chk(16'(d), 16'h0000, "reset value");
    end
    chk(16'({cor2, cor3}), 16'h0003, "correction after reset");
    reg_wr(10'h1FF, 8'hFF);
    reg_rd(10'h1FF, d);
    chk(16'(d), 16'h0000, "unmapped read");
    for (int i = 0; i < 5; i++) begin
      w = 8'($urandom);
      reg_wr(adr[i], w);
      reg_rd(adr[i], d);
      chk(16'(d), 16'(w & msk[i]), "read back");
    end
    reg_wr(ODC_ADDR_CH2_OUT, 8'h00);
    reg_wr(ODC_ADDR_CH3_OUT, 8'h00);
    reg_wr(ODC_ADDR_CH3_DIV, 8'h00);
    for (int i = 0; i < 6; i++) begin
      c = (i == 0) ? 0 : (i == 5) ? 6 : int'($urandom % 5);
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      reg_wr(ODC_ADDR_OSC_DIV, 8'(c));
      reg_wr(ODC_ADDR_CH3_CNT, d);
      wait_lvl(1'b0, t0);
      wait_lvl(1'b1, t0);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
      chk(16'(hi), 16'(exp_len(d[3:0], c)), "high time");
      chk(16'(lo), 16'(exp_len(d[7:4], c)), "low time");
    end
    reg_wr(ODC_ADDR_OSC_DIV, 8'h06);
    reg_wr(ODC_ADDR_CH3_CNT, 8'h00);
    for (int s = 0; s < 2; s++) begin
      reg_wr(ODC_ADDR_CH3_DIV, 8'(s << 4));
      sync_in <= 1'b1;
      span(10, 1'b0, 0, 1'(s));
      sync_in <= 1'b0;
    end
    reg_wr(ODC_ADDR_OSC_DIV, 8'h00);
    reg_wr(ODC_ADDR_CH3_DIV, 8'h50);
    sync_in <= 1'b1;
    wait_lvl(1'b0, t0);
    wait_lvl(1'b1, t0);
    wait_lvl(1'b0, t1);
    chk(16'(t1), 16'(exp_len(4'h0, 0)), "sync ignored");
    sync_in <= 1'b0;
    reg_wr(ODC_ADDR_OSC_DIV, 8'h06);
    reg_wr(ODC_ADDR_CH3_CNT, 8'h30);
    p = 1 + int'($urandom % 15);
    for (int k = 0; k < 2; k++) begin
      reg_wr(ODC_ADDR_CH3_DIV, 8'(k * p));
      @(posedge mclk);
      sync_in <= 1'b1;
      @(posedge mclk);
      sync_in <= 1'b0;
      repeat (2) @(posedge mclk);
      wait_lvl(1'b1, t1);
      if (k == 0) begin
        t0 = t1;
      end
    end
    chk(16'(t1 - t0), 16'(p), "phase delay");
    ce <= 1'b0;
    @(posedge mclk);
    span(10, 1'b0, 0, gda);
    ce <= 1'b1;
    reg_wr(ODC_ADDR_CH3_DIV, 8'h70);
    span(20, 1'b0, 0, 1'b1);
    reg_wr(ODC_ADDR_CH3_DIV, 8'h60);
    span(20, 1'b0, 0, 1'b0);
    reg_wr(ODC_ADDR_OSC_DIV, 8'h01);
    reg_wr(ODC_ADDR_CH3_DIV, 8'hF0);
    span(20, 1'b0, 1, 1'b0);
    reg_wr(ODC_ADDR_OSC_DIV, 8'h05);
    span(20, 1'b0, 0, 1'b0);
    reg_wr(ODC_ADDR_CH3_DIV, 8'h00);
    clk_src_sel <= ODC_SRC_OSC;
    reg_wr(ODC_ADDR_CH3_OUT, 8'h02);
    reg_wr(ODC_ADDR_CH2_OUT, 8'h02);
    span(20, 1'b0, 2, 1'b0);
    span(20, 1'b1, 2, 1'b0);
    clk_src_sel <= ODC_SRC_EXT;
    span(20, 1'b0, 3, 1'b0);
    clk_src_sel <= 2'h1;
    reg_wr(ODC_ADDR_CH3_DIV, 8'h70);
    span(20, 1'b0, 0, 1'b1);
    reg_wr(ODC_ADDR_CH2_OUT, 8'h00);
    span(20, 1'b1, 4, 1'b0);
    reg_wr(ODC_ADDR_CH3_OUT, 8'h06);
    reg_wr(ODC_ADDR_CH2_OUT, 8'h04);
    span(20, 1'b0, 0, 1'b0);
    span(20, 1'b1, 0, 1'b0);
    reg_wr(ODC_ADDR_CH3_OUT, 8'h01);
    reg_wr(ODC_ADDR_CH2_OUT, 8'h01);
    @(posedge mclk);
    chk(16'({cor2, cor3}), 16'h0000, "correction disabled");
    finish_test();
  end
endmodule
